// [hw/asc_pkg.sv]
// asc_pkg: constants shared by the static ram host controller and its bench.
// assumes a 200 mhz clock and a 55 ns class asynchronous sram outside the chip.
package asc_pkg;

	// ----------------------------------------------------------------------
	// widths and modes
	// ----------------------------------------------------------------------
	localparam int ADDR_W = 22; // word address bits 0..20, bit 21 used in byte mode
	localparam int WORD_W = 16;
	localparam int LANE_W = 8;
	localparam int EXTRA_ADDR_BIT = 21; // byte mode address bit carried on data pin 15
	localparam int EXTRA_PIN = 15;

	// ----------------------------------------------------------------------
	// timing, clock period in ps, other figures in ns, and derived cycle counts
	// ----------------------------------------------------------------------
	localparam int CLK_PS = 5000;
	localparam int T_RC_NS = 55; // read cycle, least
	localparam int T_WC_NS = 55; // write cycle, least
	localparam int T_PWE_NS = 40; // write strobe low, least
	localparam int T_HZ_NS = 20; // pins released after strobe/gate, longest wait
	localparam int RD_CYC = (T_RC_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WR_CYC = (T_PWE_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int WC_CYC = (T_WC_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int HZ_CYC = (T_HZ_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int CNT_W = 5;

	// ----------------------------------------------------------------------
	// sequencer states
	// ----------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_READ = 3'b001,
		ST_TURN = 3'b010,
		ST_WRITE = 3'b011,
		ST_HOLD = 3'b100,
		ST_RECOVER = 3'b101
	} asc_state_t;

endpackage : asc_pkg

// [hw/asc_lane_if.sv]
// asc_lane_if: per-lane pin bundle between the sequencer and the lane driver.
// assumes one instance of the lane driver per byte lane.
`timescale 1ns/1ps
interface asc_lane_if;
	logic drive;
	logic [7:0] wdata;
	logic [7:0] pin_in;
	logic [7:0] pin_out;
	logic [7:0] pin_oe;
	logic [7:0] rdata;
	modport seq (output drive, output wdata, input rdata);
	modport lane (input drive, input wdata, input pin_in, output pin_out, output pin_oe,
		output rdata);
endinterface : asc_lane_if

// [hw/asc_lane.sv]
// asc_lane: drives or releases one byte lane of the data pins.
// assumes its pin_in is sampled from the board pins, synchronous to clk_i.
`timescale 1ns/1ps
module asc_lane (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// lane bundle
	asc_lane_if.lane lane
);
	logic [7:0] out_reg, out_next;
	logic oe_reg, oe_next;
	logic [7:0] cap_reg, cap_next;

	// ----------------------------------------------------------------------
	// lane registers
	// ----------------------------------------------------------------------
	// the enable comes straight from a flop so the pin never glitches on
	always_comb begin
		out_next = lane.wdata;
		oe_next = lane.drive;
		cap_next = lane.pin_in;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			out_reg <= 8'h00;
			oe_reg <= 1'b0;
			cap_reg <= 8'h00;
		end else begin
			out_reg <= out_next;
			oe_reg <= oe_next;
			cap_reg <= cap_next;
		end
	end

	assign lane.pin_out = out_reg;
	assign lane.pin_oe = {8{oe_reg}};
	assign lane.rdata = cap_reg;
endmodule : asc_lane

// [hw/asc_host.sv]
// asc_host: host side controller for an asynchronous static ram, word or byte wide.
// assumes one request at a time; req_i is taken only while ready_o is high.
`timescale 1ns/1ps

module asc_host (
	// clock and reset
	input wire logic clk_i,
	input wire logic sys_rst_i,
	// user request
	input wire logic req_i,
	input wire logic we_i,
	input wire logic [21:0] addr_i,
	input wire logic [15:0] wdata_i,
	input wire logic [1:0] be_i,
	input wire logic byte_mode_i,
	output logic ready_o,
	output logic done_o,
	output logic [15:0] rdata_o,
	// memory pins
	output logic primary_select_n_o,
	output logic secondary_select_o,
	output logic write_strobe_n_o,
	output logic output_gate_n_o,
	output logic upper_lane_select_n_o,
	output logic lower_lane_select_n_o,
	output logic width_select_o,
	output logic [20:0] addr_o,
	input wire logic [15:0] data_i,
	output logic [15:0] data_o,
	output logic [15:0] data_oe_o
);
	asc_pkg::asc_state_t st_reg, st_next;
	logic [asc_pkg::CNT_W-1:0] cnt_reg, cnt_next;
	logic cs_n_reg, cs_n_next;
	logic we_n_reg, we_n_next;
	logic oe_n_reg, oe_n_next;
	logic [1:0] lane_n_reg, lane_n_next;
	logic [20:0] addr_reg, addr_next;
	logic [15:0] wd_reg, wd_next;
	logic wr_reg, wr_next;
	logic bm_reg, bm_next;
	logic drv_reg, drv_next;
	logic xa_reg, xa_next;
	logic ready_reg, ready_next;
	logic done_reg, done_next;
	logic [15:0] rd_reg, rd_next;
	logic sec_reg, sec_next;

	asc_lane_if lo_if ();
	asc_lane_if hi_if ();

	// ----------------------------------------------------------------------
	// access sequencer
	// ----------------------------------------------------------------------
	// every access opens with address and lanes set up before select falls, save pin 15 in byte mode, driven from that same edge
	always_comb begin
		st_next = st_reg;
		cnt_next = cnt_reg;
		cs_n_next = cs_n_reg;
		we_n_next = we_n_reg;
		oe_n_next = oe_n_reg;
		lane_n_next = lane_n_reg;
		addr_next = addr_reg;
		wd_next = wd_reg;
		wr_next = wr_reg;
		bm_next = bm_reg;
		drv_next = drv_reg;
		xa_next = xa_reg;
		ready_next = ready_reg;
		done_next = 1'b0;
		rd_next = rd_reg;
		case (st_reg)
			asc_pkg::ST_IDLE: begin
				cs_n_next = 1'b1;
				we_n_next = 1'b1;
				oe_n_next = 1'b1;
				drv_next = 1'b0;
				if (req_i && ready_reg) begin
					ready_next = 1'b0;
					wr_next = we_i;
					bm_next = byte_mode_i;
					addr_next = addr_i[20:0];
					xa_next = addr_i[asc_pkg::EXTRA_ADDR_BIT];
					wd_next = wdata_i;
					// byte mode ignores lane selects, tie both low
					lane_n_next = byte_mode_i ? 2'b00 : ~be_i;
					st_next = we_i ? asc_pkg::ST_TURN : asc_pkg::ST_READ;
					cnt_next = '0;
				end
			end
			asc_pkg::ST_READ: begin
				cs_n_next = 1'b0;
				oe_n_next = 1'b0;
				we_n_next = 1'b1;
				cnt_next = cnt_reg + 1'b1;
				// the pin input flop costs a cycle; capture one count later so the
				// sampled data is a full access time after select fell
				if (cnt_reg == asc_pkg::CNT_W'(asc_pkg::RD_CYC + 1)) begin
					rd_next = bm_reg ? {8'h00, lo_if.rdata} : {hi_if.rdata, lo_if.rdata};
					cs_n_next = 1'b1;
					oe_n_next = 1'b1;
					done_next = 1'b1;
					cnt_next = '0;
					st_next = asc_pkg::ST_RECOVER;
				end
			end
			asc_pkg::ST_TURN: begin
				// strobe low with gate high; wait out release before driving
				cs_n_next = 1'b0;
				we_n_next = 1'b0;
				oe_n_next = 1'b1;
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == asc_pkg::CNT_W'(asc_pkg::HZ_CYC)) begin
					drv_next = 1'b1;
					cnt_next = '0;
					st_next = asc_pkg::ST_WRITE;
				end
			end
			asc_pkg::ST_WRITE: begin
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == asc_pkg::CNT_W'(asc_pkg::WR_CYC)) begin
					we_n_next = 1'b1;
					cnt_next = '0;
					st_next = asc_pkg::ST_HOLD;
				end
			end
			asc_pkg::ST_HOLD: begin
				// data held one cycle past strobe rise, then let go
				cs_n_next = 1'b1;
				drv_next = 1'b0;
				done_next = 1'b1;
				st_next = asc_pkg::ST_RECOVER;
			end
			asc_pkg::ST_RECOVER: begin
				// gap keeps back to back accesses over the cycle time
				cnt_next = cnt_reg + 1'b1;
				if (cnt_reg == asc_pkg::CNT_W'(asc_pkg::HZ_CYC)) begin
					ready_next = 1'b1;
					cnt_next = '0;
					st_next = asc_pkg::ST_IDLE;
				end
			end
			default: begin
				st_next = asc_pkg::ST_IDLE;
				ready_next = 1'b1;
			end
		endcase
		// secondary select falls in the same edge as primary rises
		sec_next = !cs_n_next;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_reg <= asc_pkg::ST_IDLE;
			cnt_reg <= '0;
			cs_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			lane_n_reg <= 2'b11;
			addr_reg <= '0;
			wd_reg <= 16'h0000;
			wr_reg <= 1'b0;
			bm_reg <= 1'b0;
			drv_reg <= 1'b0;
			xa_reg <= 1'b0;
			ready_reg <= 1'b1;
			done_reg <= 1'b0;
			rd_reg <= 16'h0000;
			sec_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			cnt_reg <= cnt_next;
			cs_n_reg <= cs_n_next;
			we_n_reg <= we_n_next;
			oe_n_reg <= oe_n_next;
			lane_n_reg <= lane_n_next;
			addr_reg <= addr_next;
			wd_reg <= wd_next;
			wr_reg <= wr_next;
			bm_reg <= bm_next;
			drv_reg <= drv_next;
			xa_reg <= xa_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			rd_reg <= rd_next;
			sec_reg <= sec_next;
		end
	end

	// ----------------------------------------------------------------------
	// lane drivers
	// ----------------------------------------------------------------------
	// each lane drives only when its select is low; pin 15 carries the
	// extra address in byte mode for the whole access
	assign lo_if.drive = drv_next && !lane_n_next[0];
	assign lo_if.wdata = wd_next[7:0];
	assign lo_if.pin_in = data_i[7:0];
	// in byte mode pin 15 is an address input of the device, reads included
	assign hi_if.drive = (drv_next && !lane_n_next[1]) || (bm_next && !cs_n_next);
	assign hi_if.wdata = bm_next ? {xa_next, 7'h00} : wd_next[15:8];
	assign hi_if.pin_in = data_i[15:8];

	asc_lane u_lo (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.lane(lo_if)
	);

	asc_lane u_hi (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.lane(hi_if)
	);

	// ----------------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------------
	assign primary_select_n_o = cs_n_reg;
	assign secondary_select_o = sec_reg;
	assign write_strobe_n_o = we_n_reg;
	assign output_gate_n_o = oe_n_reg;
	assign upper_lane_select_n_o = lane_n_reg[1];
	assign lower_lane_select_n_o = lane_n_reg[0];
	assign width_select_o = !bm_reg;
	assign addr_o = addr_reg;
	assign data_o = {hi_if.pin_out, lo_if.pin_out};
	assign data_oe_o = {hi_if.pin_oe, lo_if.pin_oe};
	assign ready_o = ready_reg;
	assign done_o = done_reg;
	assign rdata_o = rd_reg;

	// ----------------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------------
	chk_idle_deselect: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(st_reg == asc_pkg::ST_IDLE) |-> (cs_n_reg && data_oe_o == 16'h0000))
		else $error("idle with device selected or pins driven");
	chk_read_levels: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!oe_n_reg) |-> (we_n_reg && !cs_n_reg && data_oe_o[7:0] == 8'h00 &&
		(bm_reg || data_oe_o[15:8] == 8'h00)))
		else $error("gate low without a clean read");
	chk_lane_drive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(data_oe_o[0] && !bm_reg) |-> !lane_n_reg[0])
		else $error("lower lane driven while its select is high");
	chk_write_window: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(we_n_reg) |-> (!cs_n_reg) [*8])
		else $error("select dropped inside the write pulse");
	chk_data_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		($rose(we_n_reg) && wr_reg) |-> $stable(data_o) && data_oe_o != 16'h0000)
		else $error("write data moved at strobe rise");
	chk_gate_write: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!we_n_reg) |-> oe_n_reg)
		else $error("gate low during a write");
	chk_turnaround: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$rose(drv_reg) |-> $past(we_n_reg, 4) == 1'b0 && oe_n_reg)
		else $error("data driven before device released the pins");
	chk_addr_stable: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		(!cs_n_reg) |-> $stable(addr_reg))
		else $error("address moved while selected");
	chk_read_done: assert property (@(posedge clk_i) disable iff (sys_rst_i)
		$fell(oe_n_reg) |-> ##[11:12] (oe_n_reg && cs_n_reg && we_n_reg))
		else $error("read did not close with strobe high");
endmodule : asc_host

// [verification/asc_sram_model.sv]
// asc_sram_model: behavioural asynchronous static ram seen through the host's registered pins.
// assumes pins only change on clk_i; it also resolves the shared data wires for the bench.
`timescale 1ns/1ps
module asc_sram_model (
	// clock
	input wire logic clk_i,
	// control pins
	input wire logic cs_n_i,
	input wire logic cs2_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic ub_n_i,
	input wire logic lb_n_i,
	input wire logic wide_i,
	// address and host data
	input wire logic [20:0] addr_i,
	input wire logic [15:0] hdata_i,
	input wire logic [15:0] hoe_i,
	// resolved wires and contention flag
	output logic [15:0] wire_o,
	output logic clash_o
);
	logic [15:0] wmem [int];
	logic [7:0] bmem [int];
	logic [15:0] last_reg = 16'h0000;
	logic [15:0] drv;
	logic [15:0] doe;
	logic [15:0] lat_d;
	logic [1:0] lat_l;
	logic lat_w;
	logic wr_q = 1'b0;
	logic sel;
	logic rd;
	logic wr;
	logic p15;
	int a;
	int lat_a;
	// deselect on an inactive chip select or on both lane selects high; byte mode has no lane selects
	assign sel = !cs_n_i && cs2_i && (!wide_i || !(ub_n_i && lb_n_i));
	assign rd = sel && we_n_i && !oe_n_i;
	assign wr = sel && !we_n_i;
	// undriven wires show the inverse of their last level, never a kind value
	assign p15 = hoe_i[15] ? hdata_i[15] : !last_reg[15];
	assign a = wide_i ? int'(addr_i) : int'({p15, addr_i});
	always_comb begin
		drv = 16'h0000;
		doe = 16'h0000;
		if (rd && wide_i) begin
			drv = wmem.exists(a) ? wmem[a] : 16'h0000;
			doe = {{8{!ub_n_i}}, {8{!lb_n_i}}};
		end else if (rd) begin
			drv[7:0] = bmem.exists(a) ? bmem[a] : 8'h00;
			doe = 16'h00ff;
		end
	end
	assign wire_o = (hoe_i & hdata_i) | (~hoe_i & doe & drv) | (~hoe_i & ~doe & ~last_reg);
	assign clash_o = |(hoe_i & doe);
	// data is taken up to the edge that ends the write, then committed
	always @(posedge clk_i) begin
		last_reg <= wire_o;
		wr_q <= wr;
		if (wr) begin
			lat_d <= wire_o;
			lat_a <= a;
			lat_w <= wide_i;
			lat_l <= {!ub_n_i, !lb_n_i};
		end
		if (wr_q && !wr && !lat_w) bmem[lat_a] = lat_d[7:0];
		if (wr_q && !wr && lat_w) begin
			if (!wmem.exists(lat_a)) wmem[lat_a] = 16'h0000;
			if (lat_l[1]) wmem[lat_a][15:8] = lat_d[15:8];
			if (lat_l[0]) wmem[lat_a][7:0] = lat_d[7:0];
		end
	end
endmodule : asc_sram_model

// [verification/async_sram_access_control_bench.sv]
// async_sram_access_control_bench: random word and byte traffic through the host controller.
// assumes the behavioural ram model; results are compared when done_o pulses.
`timescale 1ns/1ps
module async_sram_access_control_bench;
	typedef struct {logic rd; logic bm; logic [15:0] m; logic [15:0] d; int t;} asc_note_t;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic req_i = 1'b0;
	logic we_i = 1'b0;
	logic byte_mode_i = 1'b0;
	logic [21:0] addr_i = 22'h000000;
	logic [15:0] wdata_i = 16'h0000;
	logic [1:0] be_i = 2'b11;
	logic ready_o, done_o, cs_n, cs2, we_n, oe_n, ub_n, lb_n, wide, clash;
	logic [15:0] rdata_o, data_i, data_o, data_oe_o;
	logic [20:0] pin_a;
	logic [15:0] wsh [int];
	logic [7:0] bsh [int];
	logic [21:0] al [8];
	asc_note_t notes[$];
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	always #2.5 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;
	asc_host u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_i(req_i), .we_i(we_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .be_i(be_i), .byte_mode_i(byte_mode_i),
		.ready_o(ready_o), .done_o(done_o), .rdata_o(rdata_o), .primary_select_n_o(cs_n),
		.secondary_select_o(cs2), .write_strobe_n_o(we_n), .output_gate_n_o(oe_n),
		.upper_lane_select_n_o(ub_n), .lower_lane_select_n_o(lb_n), .width_select_o(wide),
		.addr_o(pin_a), .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o));
	asc_sram_model u_mem (.clk_i(clk_i), .cs_n_i(cs_n), .cs2_i(cs2), .we_n_i(we_n),
		.oe_n_i(oe_n), .ub_n_i(ub_n), .lb_n_i(lb_n), .wide_i(wide), .addr_i(pin_a),
		.hdata_i(data_o), .hoe_i(data_oe_o), .wire_o(data_i), .clash_o(clash));
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic results();
		if (fail_count == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results
	// one request held until taken; the expected answer is noted at the taking edge
	task automatic issue(input logic w, input logic [21:0] a, input logic [15:0] d,
		input logic [1:0] be, input logic bm);
		asc_note_t n;
		int k;
		k = bm ? int'(a) : int'(a[20:0]);
		n.rd = !w;
		n.bm = bm;
		n.m = bm ? 16'hffff : {{8{be[1]}}, {8{be[0]}}};
		if (!bm && !wsh.exists(k)) wsh[k] = 16'h0000;
		if (w && bm) bsh[k] = d[7:0];
		if (w && !bm) wsh[k] = (wsh[k] & ~n.m) | (d & n.m);
		n.d = bm ? {8'h00, bsh[k]} : wsh[k] & n.m;
		@(posedge clk_i);
		req_i <= 1'b1;
		we_i <= w;
		addr_i <= a;
		wdata_i <= d;
		be_i <= be;
		byte_mode_i <= bm;
		do @(negedge clk_i); while (ready_o !== 1'b1);
		@(posedge clk_i);
		n.t = cyc + 1;
		notes.push_back(n);
		req_i <= 1'b0;
	endtask : issue
	// compare each completion against the oldest note
	always @(negedge clk_i) begin : monitor
		asc_note_t n;
		if (done_o === 1'b1 && notes.size() == 0) check(32'h1, 32'h0);
		else if (done_o === 1'b1) begin
			n = notes.pop_front();
			check(cyc - n.t, n.rd ? asc_pkg::RD_CYC + 2 :
				asc_pkg::HZ_CYC + asc_pkg::WR_CYC + 3);
			if (n.rd) check(rdata_o & n.m, n.d);
			check(wide, !n.bm);
			check({ready_o, cs_n, cs2, we_n, ub_n, lb_n, data_oe_o},
				{1'b0, 3'b101, ~n.m[15], ~n.m[0], 16'h0000});
		end
		check(clash, 1'b0);
		if (we_n === 1'b0) check(oe_n, 1'b1);
	end
	initial begin
		void'($urandom(32'he33d));
		repeat (10) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		// whole words, then random lane mixes over them, read back whole or by lane
		for (int i = 0; i < 8; i++) begin
			al[i] = 22'($urandom);
			issue(1'b1, al[i], 16'($urandom), 2'b11, 1'b0);
		end
		// a request while busy must be ignored
		@(posedge clk_i);
		req_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		req_i <= 1'b0;
		for (int i = 0; i < 8; i++) begin
			issue(1'b1, al[i], 16'($urandom), 2'($urandom_range(3, 1)), 1'b0);
			issue(1'b0, al[7 - i], 16'h0000, 2'($urandom_range(3, 1)), 1'b0);
		end
		// byte mode with the top address bit both ways, then back to words
		for (int i = 0; i < 6; i++) begin
			al[i] = {i[0], 21'($urandom)};
			issue(1'b1, al[i], 16'($urandom), 2'b00, 1'b1);
			issue(1'b0, al[i], 16'h0000, 2'b11, 1'b1);
		end
		issue(1'b0, al[6], 16'h0000, 2'b11, 1'b0);
		repeat (40) @(posedge clk_i);
		check(notes.size(), 0);
		results();
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		fail_count++;
		results();
	end
endmodule : async_sram_access_control_bench
